// ==== logic/crc16_ccitt_byte_generator.sv ====
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "crc16_map.svh"

module crc16_ccitt_byte_generator
  import crc16_pkg::*;
#(
  parameter int ADDR_WIDTH = `CRC_APB_ADDR_WIDTH,
  parameter int FIFO_DEPTH = `CRC_FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // processor power state
  input wire logic [1:0] powerMode,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [`CRC_APB_DATA_WIDTH-1:0] pwdata,
  output logic pready,
  output logic [`CRC_APB_DATA_WIDTH-1:0] prdata,
  output logic pslverr
);

  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  ////////////////////////////////////////////////////////////////////////
  // power state and block reset

  logic deepStop;
  logic frozen;
  logic blockRst;

  // deep stop holds everything in reset, so recovery starts clean
  assign deepStop = (powerMode_e'(powerMode) == PWR_STOP_DEEP);
  // only the light stop freezes; wait runs as run
  assign frozen = (powerMode_e'(powerMode) == PWR_STOP_LIGHT);
  assign blockRst = sys_rst || deepStop;

  ////////////////////////////////////////////////////////////////////////
  // address decode

  logic [3:0] regIdx;
  logic idxInRange;
  accessKind_e decodedKind;

  // word index from the byte address; upper bits must be clear
  assign regIdx = paddr[5:2];
  assign idxInRange = (paddr[1:0] == 2'h0) && (paddr[ADDR_WIDTH-1:6] == '0);

  // index decode with aliases folded onto the low register
  always_comb begin
    if (!idxInRange) begin
      decodedKind = K_BAD;
    end else if (regIdx == `CRC_IDX_HIGH) begin
      decodedKind = K_SEED_HIGH;
    end else if (regIdx == `CRC_IDX_LOW) begin
      decodedKind = K_LOW;
    end else if (regIdx >= `CRC_IDX_ALIAS_FIRST && regIdx <= `CRC_IDX_ALIAS_LAST) begin
      decodedKind = K_LOW;
    end else if (regIdx == `CRC_IDX_STATUS) begin
      decodedKind = K_STATUS;
    end else begin
      decodedKind = K_BAD;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // data path instances

  crc_byte_stream_if #(.WIDTH(`CRC_BYTE_WIDTH)) stream ();

  logic fifoInValid;
  logic fifoInReady;
  logic [LW-1:0] fifoLevel;
  logic seedHighLoad;
  logic seedLowLoad;
  logic [`CRC_WIDTH-1:0] crcValue;

  crc_byte_fifo #(
    .WIDTH(`CRC_BYTE_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rst(blockRst),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(pwdata[`CRC_BYTE_WIDTH-1:0]),
    .out(stream.src),
    .level(fifoLevel)
  );

  crc_shift_engine #(
    .POLY(`CRC_POLY)
  ) u_engine (
    .clk(ref_clk),
    .rst(blockRst),
    .freeze(frozen),
    .seedHighLoad(seedHighLoad),
    .seedLowLoad(seedLowLoad),
    .seedByte(pwdata[`CRC_BYTE_WIDTH-1:0]),
    .in(stream.snk),
    .crc(crcValue)
  );

  ////////////////////////////////////////////////////////////////////////
  // access admission

  logic access;
  logic drained;
  logic canGo;
  logic seedPending;

  // an access is the enable phase of a selected transfer
  assign access = psel && penable;
  // all queued bytes absorbed, so the result is current
  assign drained = !stream.valid;

  // data writes wait for room, seeds and result reads wait for drain
  always_comb begin
    canGo = 1'b1;
    if (decodedKind == K_LOW && pwrite && !seedPending) begin
      canGo = fifoInReady;
    end else if (decodedKind == K_SEED_HIGH || decodedKind == K_LOW) begin
      canGo = drained;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // answer sequencer

  apbState_e state;
  accessKind_e heldKind;
  logic heldWrite;

  // one response cycle per transfer, pready from a flop
  always_ff @(posedge ref_clk) begin
    if (blockRst) begin
      state <= ST_IDLE;
      pready <= 1'b0;
      heldKind <= K_BAD;
      heldWrite <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (access && canGo) begin
            state <= ST_RESP;
            pready <= 1'b1;
            heldKind <= decodedKind;
            heldWrite <= pwrite;
          end
        end
        ST_RESP: begin
          state <= ST_IDLE;
          pready <= 1'b0;
        end
        default: begin
          state <= ST_IDLE;
          pready <= 1'b0;
        end
      endcase
    end
  end

  // error answer for unmapped indices
  always_ff @(posedge ref_clk) begin
    if (blockRst) begin
      pslverr <= 1'b0;
    end else if (state == ST_IDLE && access && canGo) begin
      pslverr <= (decodedKind == K_BAD);
    end else begin
      pslverr <= 1'b0;
    end
  end

  // read data captured with the answer; unused bits read zero
  always_ff @(posedge ref_clk) begin
    if (blockRst) begin
      prdata <= '0;
    end else if (state == ST_IDLE && access && canGo && !pwrite) begin
      prdata <= '0;
      if (decodedKind == K_SEED_HIGH) begin
        prdata[7:0] <= crcValue[15:8];
      end else if (decodedKind == K_LOW) begin
        prdata[7:0] <= crcValue[7:0];
      end else if (decodedKind == K_STATUS) begin
        prdata[`CRC_STAT_SEED_PENDING] <= seedPending;
        prdata[`CRC_STAT_FIFO_EMPTY] <= drained;
        prdata[`CRC_STAT_FROZEN] <= frozen;
        prdata[`CRC_STAT_LEVEL_LSB +: LW] <= fifoLevel;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write effects at the completing edge

  logic commitWrite;

  assign commitWrite = (state == ST_RESP) && heldWrite;
  assign seedHighLoad = commitWrite && (heldKind == K_SEED_HIGH);
  assign seedLowLoad = commitWrite && (heldKind == K_LOW) && seedPending;
  assign fifoInValid = commitWrite && (heldKind == K_LOW) && !seedPending;

  // seed capture armed by a high write, disarmed by the low seed byte
  always_ff @(posedge ref_clk) begin
    if (blockRst) begin
      seedPending <= 1'b0;
    end else if (seedHighLoad) begin
      seedPending <= 1'b1;
    end else if (seedLowLoad) begin
      seedPending <= 1'b0;
    end
  end

endmodule : crc16_ccitt_byte_generator

`default_nettype wire

// ==== logic/crc16_map.svh ====
`ifndef CRC16_MAP_SVH
`define CRC16_MAP_SVH

// register indices; byte address is four times the index
`define CRC_IDX_HIGH 4'h0
`define CRC_IDX_LOW 4'h1
`define CRC_IDX_ALIAS_FIRST 4'h4
`define CRC_IDX_ALIAS_LAST 4'h7
`define CRC_IDX_STATUS 4'h8

// status register field positions
`define CRC_STAT_SEED_PENDING 0
`define CRC_STAT_FIFO_EMPTY 1
`define CRC_STAT_FROZEN 2
`define CRC_STAT_LEVEL_LSB 4

// shift register and data path
`define CRC_WIDTH 16
`define CRC_BYTE_WIDTH 8
`define CRC_POLY 16'h1021
`define CRC_RESET_VALUE 16'h0000
`define CRC_FIFO_DEPTH 8

// bus shape
`define CRC_APB_ADDR_WIDTH 12
`define CRC_APB_DATA_WIDTH 32

`endif

// ==== logic/crc16_pkg.sv ====
`default_nettype none

package crc16_pkg;

  // processor power state seen by the block
  typedef enum logic [1:0] {
    PWR_RUN = 2'h0,
    PWR_WAIT = 2'h1,
    PWR_STOP_LIGHT = 2'h2,
    PWR_STOP_DEEP = 2'h3
  } powerMode_e;

  // bus answer sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RESP = 2'b10
  } apbState_e;

  // what a decoded access does
  typedef enum logic [2:0] {
    K_SEED_HIGH = 3'h0,
    K_LOW = 3'h1,
    K_STATUS = 3'h2,
    K_BAD = 3'h3
  } accessKind_e;

endpackage : crc16_pkg

`default_nettype wire

// ==== logic/crc_byte_stream_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// byte stream from the data buffer to the shift engine
interface crc_byte_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : crc_byte_stream_if

`default_nettype wire

// ==== logic/crc_byte_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none

module crc_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // draining side
  crc_byte_stream_if.src out,
  // fill level
  output logic [$clog2(DEPTH):0] level
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [PW:0] count;
  logic push;
  logic pop;

  // honest full and empty
  assign inReady = (count != DEPTH[PW:0]);
  assign out.valid = (count != '0);
  assign out.data = mem[rdPtr];
  assign push = inValid && inReady;
  assign pop = out.valid && out.ready;
  assign level = count;

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  // pointers wrap at depth
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
    end
  end

  // occupancy
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + 1'b1;
    end else if (pop && !push) begin
      count <= count - 1'b1;
    end
  end

endmodule : crc_byte_fifo

`default_nettype wire

// ==== logic/crc_shift_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "crc16_map.svh"

module crc_shift_engine #(
  parameter logic [`CRC_WIDTH-1:0] POLY = `CRC_POLY
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // standby freeze
  input wire logic freeze,
  // seed loads
  input wire logic seedHighLoad,
  input wire logic seedLowLoad,
  input wire logic [`CRC_BYTE_WIDTH-1:0] seedByte,
  // data bytes
  crc_byte_stream_if.snk in,
  // running result
  output logic [`CRC_WIDTH-1:0] crc
);

  // chain of single-bit steps, msb of the byte first
  logic [`CRC_WIDTH-1:0] stage [`CRC_BYTE_WIDTH+1];

  assign stage[0] = crc;

  genvar b;
  generate
    for (b = 0; b < `CRC_BYTE_WIDTH; b++) begin : g_bit
      logic fb;
      assign fb = stage[b][`CRC_WIDTH-1] ^ in.data[`CRC_BYTE_WIDTH-1-b];
      assign stage[b+1] = {stage[b][`CRC_WIDTH-2:0], 1'b0} ^ (fb ? POLY : '0);
    end
  endgenerate

  // frozen standby accepts no data bytes; seed loads still apply
  assign in.ready = !freeze;

  // shift register update
  always_ff @(posedge clk) begin
    if (rst) begin
      crc <= `CRC_RESET_VALUE;
    end else if (seedHighLoad) begin
      crc[15:8] <= seedByte;
    end else if (seedLowLoad) begin
      crc[7:0] <= seedByte;
    end else if (in.valid && in.ready) begin
      crc <= stage[`CRC_BYTE_WIDTH];
    end
  end

endmodule : crc_shift_engine

`default_nettype wire

// ==== test/crc16_ccitt_byte_generator_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module crc16_ccitt_byte_generator_properties #(
  parameter int ADDR_WIDTH = 12
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [1:0] powerMode,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////
  // bus answer rules
  chk_rst_quiet: assert property (disable iff (1'b0) sys_rst |=> !pready && prdata == 32'h0)
    else $error("bus active after reset");
  chk_deep_clear: assert property (powerMode == 2'h3 |=> !pready && prdata == 32'h0)
    else $error("deep stop did not clear");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than a cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_ready_cause: assert property (pready |-> psel && penable)
    else $error("ready without access");
  chk_answer_wait: assert property (psel && $rose(penable) |-> !pready)
    else $error("ready in first access cycle");
  chk_misalign_err: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access accepted");
  chk_alias_ok: assert property (pready && paddr[1:0] == 2'h0 && paddr[ADDR_WIDTH-1:2] inside {4, 5, 6, 7} |-> !pslverr)
    else $error("alias refused");
  chk_regs_ok: assert property (pready && paddr[ADDR_WIDTH-1:3] == 0 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("result register refused");
  chk_rdata_src: assert property ($changed(prdata) |-> (pready && !pwrite) || $past(powerMode) == 2'h3)
    else $error("read data moved without read");
  // main scenarios
  cover property (pready && pslverr);
  cover property (pready && !pwrite && paddr == 'h4);
  cover property (powerMode == 2'h2 && pready);
endmodule : crc16_ccitt_byte_generator_properties
bind crc16_ccitt_byte_generator crc16_ccitt_byte_generator_properties #(.ADDR_WIDTH(ADDR_WIDTH)) i_props (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .powerMode(powerMode), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
`default_nettype wire

// ==== test/tb_crc16_ccitt_byte_generator.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "crc16_map.svh"
module tb_crc16_ccitt_byte_generator;
  logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, er;
  logic [1:0] powerMode;
  logic [11:0] paddr, a;
  logic [31:0] pwdata, prdata, rd, t;
  logic [31:0] rng = 32'h0000A0FE;
  logic [15:0] m;
  int mismatches, n_compared, n;
  crc16_ccitt_byte_generator i_crc16_ccitt_byte_generator (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .powerMode(powerMode), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  // clock
  always #10 ref_clk = ~ref_clk;
  ////////////////////
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs
  // msb-first reference step
  function automatic logic [15:0] nxt(logic [15:0] c, logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      c = c[15] ^ b[i] ? {c[14:0], 1'b0} ^ `CRC_POLY : {c[14:0], 1'b0};
    end
    return c;
  endfunction : nxt
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic end_sim();
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // one apb transfer, held until pready
  task automatic apb(logic w, logic [11:0] ad, logic [7:0] d);
    int k;
    psel <= 1'b1; pwrite <= w; paddr <= ad; pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge ref_clk); k++; end while (pready !== 1'b1 && k < 200);
    if (k >= 200) mismatches++;
    rd = prdata; er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic rdc(logic [11:0] ad, logic [31:0] e);
    apb(1'b0, ad, 8'h00);
    chk("read", rd, e);
  endtask : rdc
  task automatic seedc(logic [15:0] s);
    apb(1'b1, 12'h000, s[15:8]); apb(1'b1, 12'h004, s[7:0]); m = s;
  endtask : seedc
  task automatic dat(logic [11:0] ad, logic [7:0] b);
    apb(1'b1, ad, b); m = nxt(m, b);
  endtask : dat
  task automatic rres();
    rdc(12'h000, {24'h0, m[15:8]}); rdc(12'h004, {24'h0, m[7:0]});
  endtask : rres
  ////////////////////
  // main sequence
  initial begin
    ref_clk = 0; sys_rst = 1; powerMode = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    m = 16'h0000; rres();
    rdc(12'h020, 32'h2);
    seedc(16'hFFFF); dat(12'h004, 8'h41); rdc(12'h000, 32'hB9); rdc(12'h004, 32'h15);
    seedc(16'h1D0F);
    for (int i = 0; i < 9; i++) dat(12'h004, 8'h31 + i[7:0]);
    rdc(12'h000, 32'hE5); rdc(12'h004, 32'hCC);
    apb(1'b1, 12'h000, 8'hAA); apb(1'b1, 12'h000, 8'h5C); apb(1'b1, 12'h004, 8'h3E); m = 16'h5C3E; rres();
    for (int k = 0; k < 20; k++) begin
      t = xs(); seedc(t[15:0]); n = 1 + int'(t[31:16] % 12);
      for (int j = 0; j < n; j++) begin
        t = xs(); powerMode <= {1'b0, t[8]}; a = t[9] ? 12'h010 + {t[11:10], 2'h0} : 12'h004;
        dat(a, t[7:0]);
        if (j == 0) rres();
      end
      rres();
    end
    powerMode <= 2'h2;
    @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin t = xs(); dat(12'h004, t[7:0]); end
    rdc(12'h020, 32'h84);
    fork
      begin repeat (20) @(posedge ref_clk); powerMode <= 2'h0; end
      dat(12'h004, 8'h77);
    join
    rres();
    powerMode <= 2'h3;
    repeat (2) @(posedge ref_clk);
    powerMode <= 2'h0;
    @(posedge ref_clk);
    m = 16'h0000; rres(); dat(12'h004, 8'h5A); rres();
    apb(1'b0, 12'h008, 8'h00); chk("unmapped", {31'h0, er}, 32'h1);
    apb(1'b1, 12'h002, 8'hFF); chk("misaligned", {31'h0, er}, 32'h1);
    apb(1'b1, 12'h020, 8'hFF); chk("status write", {31'h0, er}, 32'h0); rres();
    end_sim();
  end
  // watchdog
  initial begin
    #1000000;
    mismatches++;
    end_sim();
  end
endmodule : tb_crc16_ccitt_byte_generator
`default_nettype wire
